// ==== rtl/wtc_pkg.sv ====
package wtc_pkg;

	// apb byte addresses
	localparam logic [11:0] CTRL_ADDR     = 12'h0d8;
	localparam logic [11:0] IRQ_EN_ADDR   = 12'h0e8;
	localparam logic [11:0] EVT_STAT_ADDR = 12'h100;
	localparam logic [11:0] EVT_MASK_ADDR = 12'h104;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic rsv7;
		logic power_on_flag;
		logic rsv5;
		logic wdt_clock_select;
		logic wdt_timeout_flag;
		logic wdt_reset_flag;
		logic wdt_reset_enable;
		logic wdt_restart;
	} wtc_ctrl_s;

	// extended interrupt enable: watchdog gate bit, reserved top bits
	localparam int          WDT_IRQ_EN_BIT = 5;
	localparam logic [7:0]  IRQ_EN_WR_MASK = 8'h3f;

	// event status / mask layout
	localparam int          EVT_W          = 2;
	localparam int          EVT_TIMEOUT    = 0;
	localparam int          EVT_WD_RESET   = 1;

	// reset values
	localparam logic [7:0]  CTRL_POR_VAL   = 8'h40;
	localparam logic [7:0]  IRQ_EN_RST     = 8'h00;
	localparam logic [1:0]  EVT_RST        = 2'h0;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

	// clocks from an unserviced time-out to the watchdog reset
	localparam int          RST_DELAY_CLKS = 512;
	localparam int          DLY_W          = 9;
	localparam logic [8:0]  DLY_LAST       = 9'(RST_DELAY_CLKS - 1);

	// default time-out interval in counter ticks
	localparam int          TIMEOUT_TICKS_DEF = 32768;

	typedef enum logic {
		WD_RUN   = 1'b0,
		WD_GRACE = 1'b1
	} wtc_wd_state_e;

endpackage : wtc_pkg

// ==== rtl/wtc_top.sv ====
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module wtc_top #(
	parameter int unsigned TIMEOUT_TICKS = wtc_pkg::TIMEOUT_TICKS_DEF
) (
	input  wire logic        mclk_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        sub_osc_clock_in,
	input  wire logic        ext_rst_n_in,
	input  wire logic        pwr_fail_rst_n_in,
	input  wire logic        global_irq_enable_in,
	output logic             wd_irq_req_out,
	output logic             wd_sys_reset_out,
	output logic             irq_out
);

	localparam int              CNT_W   = $clog2(TIMEOUT_TICKS);
	localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_TICKS - 1);

	wtc_pkg::wtc_ctrl_s          ctrl;
	wtc_pkg::wtc_ctrl_s          next_ctrl;
	wtc_pkg::wtc_wd_state_e      state;
	wtc_pkg::wtc_wd_state_e      next_state;
	logic [7:0]                  irq_en;
	logic [7:0]                  next_irq_en;
	logic [wtc_pkg::EVT_W-1:0]   evt_stat;
	logic [wtc_pkg::EVT_W-1:0]   next_evt_stat;
	logic [wtc_pkg::EVT_W-1:0]   evt_mask;
	logic [CNT_W-1:0]            watchdog_counter;
	logic [CNT_W-1:0]            next_counter;
	logic [wtc_pkg::DLY_W-1:0]   dly_cnt;
	logic [wtc_pkg::DLY_W-1:0]   next_dly_cnt;
	logic [2:0]                  sub_sync;
	logic [1:0]                  ext_sync;
	logic [1:0]                  pf_sync;

	// pin synchronisers; edge detect reads only the second and third stage
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			sub_sync <= 3'h0;
			ext_sync <= 2'h3;
			pf_sync  <= 2'h3;
		end else begin
			sub_sync <= {sub_sync[1:0], sub_osc_clock_in};
			ext_sync <= {ext_sync[0], ext_rst_n_in};
			pf_sync  <= {pf_sync[0], pwr_fail_rst_n_in};
		end
	end

	wire sub_rise = sub_sync[1] & ~sub_sync[2];
	wire ext_rst  = ~ext_sync[1];
	wire pf_rst   = ~pf_sync[1];
	wire sys_rst  = ext_rst | pf_rst;

	// apb decode
	wire apb_setup  = psel_in & ~penable_in;
	wire apb_wr     = psel_in & penable_in & pready_out & pwrite_in & pstrb_in[0];
	wire hit_ctrl   = (paddr_in == wtc_pkg::CTRL_ADDR);
	wire hit_irq_en = (paddr_in == wtc_pkg::IRQ_EN_ADDR);
	wire hit_stat   = (paddr_in == wtc_pkg::EVT_STAT_ADDR);
	wire hit_mask   = (paddr_in == wtc_pkg::EVT_MASK_ADDR);
	wire mapped     = hit_ctrl | hit_irq_en | hit_stat | hit_mask;
	wire wr_ctrl    = apb_wr & hit_ctrl;
	wire wr_irq_en  = apb_wr & hit_irq_en;
	wire wr_stat    = apb_wr & hit_stat;
	wire wr_mask    = apb_wr & hit_mask;
	wire [7:0] wbyte = pwdata_in[7:0];

	wire [31:0] rd_data =
		hit_ctrl   ? {24'h0, ctrl} :
		hit_irq_en ? {24'h0, irq_en} :
		hit_stat   ? {30'h0, evt_stat} :
		hit_mask   ? {30'h0, evt_mask} : 32'h0;

	// counter tick source and time-out detection
	wire tick    = ctrl.wdt_clock_select ? sub_rise : 1'b1;
	wire restart = ctrl.wdt_restart;
	wire timeout = tick & (watchdog_counter == TO_LAST) & ~restart & ~sys_rst;
	wire grace_end = (state == wtc_pkg::WD_GRACE) & (dly_cnt == wtc_pkg::DLY_LAST);
	wire wd_fire = grace_end & ctrl.wdt_reset_enable & ~restart & ~sys_rst;
	wire any_rst = sys_rst | wd_fire;

	always_comb begin
		next_counter = watchdog_counter;
		if (any_rst || restart) begin
			next_counter = '0;
		end else if (tick) begin
			next_counter = timeout ? '0 : CNT_W'(watchdog_counter + 1'b1);
		end
	end

	// grace window between time-out and watchdog reset
	always_comb begin
		next_state   = state;
		next_dly_cnt = dly_cnt;
		case (state)
			wtc_pkg::WD_RUN: begin
				next_dly_cnt = '0;
				if (timeout) begin
					next_state = wtc_pkg::WD_GRACE;
				end
			end
			wtc_pkg::WD_GRACE: begin
				next_dly_cnt = wtc_pkg::DLY_W'(dly_cnt + 1'b1);
				if (any_rst || restart || grace_end) begin
					next_state   = wtc_pkg::WD_RUN;
					next_dly_cnt = '0;
				end
			end
			default: begin
				next_state   = wtc_pkg::WD_RUN;
				next_dly_cnt = '0;
			end
		endcase
	end

	// control register: write, hardware set, reset-type loads
	always_comb begin
		next_ctrl = ctrl;
		next_ctrl.wdt_restart = 1'b0;
		if (wr_ctrl) begin
			next_ctrl.power_on_flag    = ctrl.power_on_flag & wbyte[6];
			next_ctrl.wdt_clock_select = wbyte[4];
			next_ctrl.wdt_timeout_flag = wbyte[3];
			next_ctrl.wdt_reset_flag   = ctrl.wdt_reset_flag & wbyte[2];
			next_ctrl.wdt_reset_enable = wbyte[1];
			next_ctrl.wdt_restart      = wbyte[0];
		end
		if (timeout) begin
			next_ctrl.wdt_timeout_flag = 1'b1;
		end
		if (any_rst) begin
			next_ctrl.wdt_clock_select = 1'b0;
			next_ctrl.wdt_timeout_flag = 1'b0;
			next_ctrl.wdt_restart      = 1'b0;
		end
		if (pf_rst) begin
			next_ctrl.wdt_reset_flag = 1'b0;
		end
		if (wd_fire) begin
			next_ctrl.wdt_reset_flag = 1'b1;
		end
		next_ctrl.rsv7 = 1'b0;
		next_ctrl.rsv5 = 1'b0;
	end

	always_comb begin
		next_irq_en = irq_en;
		if (any_rst) begin
			next_irq_en = wtc_pkg::IRQ_EN_RST;
		end else if (wr_irq_en) begin
			next_irq_en = wbyte & wtc_pkg::IRQ_EN_WR_MASK;
		end
	end

	// sticky events: write one clears, a new event wins
	wire [wtc_pkg::EVT_W-1:0] evt_set = {wd_fire, timeout};
	wire [wtc_pkg::EVT_W-1:0] evt_clr = wr_stat ? wbyte[wtc_pkg::EVT_W-1:0] : '0;
	assign next_evt_stat = (evt_stat & ~evt_clr) | evt_set;

	wire req_now = ctrl.wdt_timeout_flag & irq_en[wtc_pkg::WDT_IRQ_EN_BIT] & global_irq_enable_in;

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			ctrl             <= wtc_pkg::CTRL_POR_VAL;
			irq_en           <= wtc_pkg::IRQ_EN_RST;
			state            <= wtc_pkg::WD_RUN;
			watchdog_counter <= '0;
			dly_cnt          <= '0;
		end else begin
			ctrl             <= next_ctrl;
			irq_en           <= next_irq_en;
			state            <= next_state;
			watchdog_counter <= next_counter;
			dly_cnt          <= next_dly_cnt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			evt_stat <= wtc_pkg::EVT_RST;
			evt_mask <= wtc_pkg::EVT_RST;
			irq_out  <= 1'b0;
		end else begin
			evt_stat <= next_evt_stat;
			evt_mask <= wr_mask ? wbyte[wtc_pkg::EVT_W-1:0] : evt_mask;
			irq_out  <= |(evt_stat & evt_mask);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			wd_irq_req_out   <= 1'b0;
			wd_sys_reset_out <= 1'b0;
		end else begin
			wd_irq_req_out   <= req_now;
			wd_sys_reset_out <= wd_fire;
		end
	end

	// apb answer: ready in the access phase, data captured at setup
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= wtc_pkg::RDATA_RST;
		end else begin
			pready_out  <= apb_setup;
			pslverr_out <= apb_setup & ~mapped;
			prdata_out  <= apb_setup ? rd_data : prdata_out;
		end
	end

	// checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	chk_por_clear_sw: assert property (
		$fell(ctrl.power_on_flag) |-> $past(wr_ctrl))
		else $error("power-on flag cleared without a write");

	chk_sub_clock_hold: assert property (
		ctrl.wdt_clock_select && !sub_rise && !restart && !any_rst |=> $stable(watchdog_counter))
		else $error("counter moved without a sub-oscillator edge");

	chk_main_clock_count: assert property (
		!ctrl.wdt_clock_select && !restart && !any_rst && watchdog_counter != TO_LAST
		|=> watchdog_counter == CNT_W'($past(watchdog_counter) + 1'b1))
		else $error("counter did not follow the main clock");

	chk_timeout_flag_set: assert property (
		timeout && !wd_fire |=> ctrl.wdt_timeout_flag && evt_stat[wtc_pkg::EVT_TIMEOUT])
		else $error("time-out did not set the flag");

	chk_irq_request: assert property (
		wd_irq_req_out == $past(req_now) && (!wd_irq_req_out || $past(ctrl.wdt_timeout_flag)))
		else $error("watchdog interrupt request wrong");

	chk_timeout_clear: assert property (
		$fell(ctrl.wdt_timeout_flag) |-> $past(wr_ctrl || any_rst))
		else $error("time-out flag cleared by hardware");

	chk_wd_reset_load: assert property (
		wd_fire && !sys_rst |=> ctrl.wdt_reset_flag && !ctrl.wdt_clock_select
		&& !ctrl.wdt_timeout_flag && !ctrl.wdt_restart && $stable(ctrl.wdt_reset_enable))
		else $error("watchdog reset load wrong");

	chk_reset_flag_cause: assert property (
		$rose(ctrl.wdt_reset_flag) |-> $past(ctrl.wdt_reset_enable) && $past(wd_fire))
		else $error("reset flag set while reset disabled");

	chk_reset_armed: assert property (
		wd_sys_reset_out |-> $past(ctrl.wdt_reset_enable) && $past(dly_cnt) == wtc_pkg::DLY_LAST)
		else $error("system reset without enable or at wrong delay");

	chk_restart_self: assert property (
		restart && !wr_ctrl |=> !ctrl.wdt_restart && watchdog_counter == '0 && state == wtc_pkg::WD_RUN)
		else $error("restart did not act or stayed set");

	chk_grace_entry: assert property (
		state == wtc_pkg::WD_RUN && timeout |=> state == wtc_pkg::WD_GRACE && dly_cnt == '0)
		else $error("grace window not started on time-out");

	chk_ext_reset_load: assert property (
		ext_rst && !pf_rst && !wd_fire |=> $stable(ctrl.wdt_reset_flag) && $stable(ctrl.power_on_flag)
		&& $stable(ctrl.wdt_reset_enable) && !ctrl.wdt_clock_select && !ctrl.wdt_timeout_flag)
		else $error("external reset load wrong");

	chk_pf_reset_flag: assert property (
		pf_rst && !wd_fire |=> !ctrl.wdt_reset_flag && $stable(ctrl.wdt_reset_enable))
		else $error("power-fail reset did not clear reset flag");

	chk_por_value: assert property (
		$rose(nrst_in) |-> ctrl == wtc_pkg::CTRL_POR_VAL)
		else $error("power-on control value wrong");

	chk_irq_en_rsv: assert property (
		irq_en[7:6] == 2'h0 && ctrl.rsv7 == 1'b0 && ctrl.rsv5 == 1'b0)
		else $error("reserved bits set");

	chk_ready_pulse: assert property (
		pready_out == $past(apb_setup))
		else $error("ready not one cycle after setup");

	chk_slverr_ready: assert property (
		pslverr_out |-> pready_out)
		else $error("error response without ready");

	chk_rdata_upper: assert property (
		prdata_out[31:8] == 24'h0)
		else $error("upper read data bits not zero");

	chk_por_flag_hold: assert property (
		ctrl.power_on_flag && !wr_ctrl |=> ctrl.power_on_flag)
		else $error("power-on flag lost without a write");

	chk_gie_gate: assert property (
		!global_irq_enable_in |=> !wd_irq_req_out)
		else $error("watchdog request with global enable low");

	chk_timeout_hold: assert property (
		ctrl.wdt_timeout_flag && !wr_ctrl && !any_rst |=> ctrl.wdt_timeout_flag)
		else $error("time-out flag lost without write or reset");

	chk_reset_flag_hold: assert property (
		ctrl.wdt_reset_flag && !wr_ctrl && !pf_rst |=> ctrl.wdt_reset_flag)
		else $error("reset flag lost without write or power-fail");

	chk_no_fire_disabled: assert property (
		!ctrl.wdt_reset_enable |=> !wd_sys_reset_out)
		else $error("system reset while reset disabled");

	chk_restart_counter: assert property (
		restart |=> watchdog_counter == '0)
		else $error("restart did not clear the counter");

	chk_grace_count: assert property (
		state == wtc_pkg::WD_GRACE && !grace_end && !any_rst && !restart
		|=> state == wtc_pkg::WD_GRACE && dly_cnt == $past(dly_cnt) + 1'b1)
		else $error("grace counter did not advance");

	chk_reset_pulse: assert property (
		wd_sys_reset_out |=> !wd_sys_reset_out)
		else $error("system reset longer than one cycle");

	chk_irq_en_clear: assert property (
		sys_rst |=> irq_en == wtc_pkg::IRQ_EN_RST)
		else $error("irq enable not cleared by reset");

	chk_event_sticky: assert property (
		evt_stat[wtc_pkg::EVT_TIMEOUT] && !wr_stat |=> evt_stat[wtc_pkg::EVT_TIMEOUT])
		else $error("time-out event lost without a clear");

	chk_irq_out_level: assert property (
		irq_out == $past(|(evt_stat & evt_mask)))
		else $error("interrupt output does not follow events");

	cov_sub_tick: cover property (ctrl.wdt_clock_select && sub_rise);
	cov_timeout: cover property (timeout);
	cov_wd_reset: cover property (wd_sys_reset_out);
	cov_restart_in_grace: cover property (state == wtc_pkg::WD_GRACE && restart);
	cov_irq: cover property ($rose(irq_out));

endmodule : wtc_top

`default_nettype wire

// ==== testbench/wtc_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module wtc_bench;
	localparam logic [11:0] CA = wtc_pkg::CTRL_ADDR;
	localparam logic [11:0] IA = wtc_pkg::IRQ_EN_ADDR;
	localparam logic [11:0] SA = wtc_pkg::EVT_STAT_ADDR;
	localparam logic [11:0] MA = wtc_pkg::EVT_MASK_ADDR;

	typedef struct {
		logic        wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic        err;
	} wtc_row_s;

	logic        mclk_in    = 1'b0;
	logic        nrst_in    = 1'b0;
	logic        psel_in    = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in  = 1'b0;
	logic [11:0] paddr_in   = 12'h000;
	logic [31:0] pwdata_in  = 32'h0;
	logic        sub_osc    = 1'b0;
	logic        ext_rst_n  = 1'b1;
	logic        pf_rst_n   = 1'b1;
	logic        gie        = 1'b1;
	logic [3:0]  strb       = 4'hf;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        wd_irq_req_out;
	logic        wd_sys_reset_out;
	logic        irq_out;
	logic [31:0] rdv;
	logic        erv;
	int          error_cnt  = 0;
	int          cmp_count  = 0;
	int          rst_seen   = 0;
	int          n;
	int          r0;

	// ordinary register accesses: direction, address, write data, read data, error
	wtc_row_s rows [11] = '{
		'{1'b0, CA, 32'h0, 32'h40, 1'b0},
		'{1'b1, CA, 32'h50, 32'h0, 1'b0},
		'{1'b0, CA, 32'h0, 32'h50, 1'b0},
		'{1'b0, IA, 32'h0, 32'h00, 1'b0},
		'{1'b1, IA, 32'hff, 32'h0, 1'b0},
		'{1'b0, IA, 32'h0, 32'h3f, 1'b0},
		'{1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1},
		'{1'b1, CA, 32'h11, 32'h0, 1'b0},
		'{1'b0, CA, 32'h0, 32'h10, 1'b0},
		'{1'b1, MA, 32'h3, 32'h0, 1'b0},
		'{1'b0, MA, 32'h0, 32'h3, 1'b0}
	};

	always #20 mclk_in = ~mclk_in;

	always @(posedge mclk_in) begin
		if (wd_sys_reset_out === 1'b1) begin
			rst_seen++;
		end
	end

	wtc_top #(.TIMEOUT_TICKS(16)) wtc_top_inst (
		.mclk_in              (mclk_in),
		.nrst_in              (nrst_in),
		.psel_in              (psel_in),
		.penable_in           (penable_in),
		.pwrite_in            (pwrite_in),
		.paddr_in             (paddr_in),
		.pwdata_in            (pwdata_in),
		.pstrb_in             (strb),
		.prdata_out           (prdata_out),
		.pready_out           (pready_out),
		.pslverr_out          (pslverr_out),
		.sub_osc_clock_in     (sub_osc),
		.ext_rst_n_in         (ext_rst_n),
		.pwr_fail_rst_n_in    (pf_rst_n),
		.global_irq_enable_in (gie),
		.wd_irq_req_out       (wd_irq_req_out),
		.wd_sys_reset_out     (wd_sys_reset_out),
		.irq_out              (irq_out)
	);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task end_of_test;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// one apb transfer, request held until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
		int k;
		k = 0;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 50);
		if (k >= 50) error_cnt++;
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, rdv, erv);
	endtask : wr

	task rc(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0, rdv, erv);
		chk(rdv, {24'h0, e});
	endtask : rc

	task sub_tick;
		sub_osc <= 1'b1;
		repeat (3) @(posedge mclk_in);
		sub_osc <= 1'b0;
		repeat (3) @(posedge mclk_in);
	endtask : sub_tick

	task pulse_rst(input int which);
		@(posedge mclk_in);
		if (which == 0) nrst_in <= 1'b0;
		else if (which == 1) ext_rst_n <= 1'b0;
		else pf_rst_n <= 1'b0;
		repeat (4) @(posedge mclk_in);
		nrst_in <= 1'b1;
		ext_rst_n <= 1'b1;
		pf_rst_n <= 1'b1;
		repeat (4) @(posedge mclk_in);
	endtask : pulse_rst

	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		end_of_test;
	end

	initial begin
		repeat (4) @(posedge mclk_in);
		nrst_in <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d, rdv, erv);
			if (!rows[i].wr) chk(rdv, rows[i].exp);
			chk({31'h0, erv}, {31'h0, rows[i].err});
		end
		strb <= 4'h0;
		wr(IA, 8'h00);
		strb <= 4'hf;
		rc(IA, 8'h3f);
		repeat (40) @(posedge mclk_in);
		rc(CA, 8'h10);
		repeat (15) sub_tick;
		rc(CA, 8'h10);
		sub_tick;
		rc(CA, 8'h18);
		chk({31'h0, wd_irq_req_out}, 32'h1);
		rc(SA, 8'h01);
		chk({31'h0, irq_out}, 32'h1);
		gie <= 1'b0;
		repeat (3) @(posedge mclk_in);
		chk({31'h0, wd_irq_req_out}, 32'h0);
		wr(MA, 8'h00);
		repeat (3) @(posedge mclk_in);
		chk({31'h0, irq_out}, 32'h0);
		wr(SA, 8'h01);
		rc(SA, 8'h00);
		wr(CA, 8'h10);
		rc(CA, 8'h10);
		// restart ends the pending grace window, then an armed time-out runs into a system reset
		wr(CA, 8'h03);
		n = 0;
		while (rst_seen == 0 && n < 800) begin
			@(posedge mclk_in);
			n++;
		end
		chk(32'(n >= 512 && n <= 540), 32'h1);
		repeat (2) @(posedge mclk_in);
		rc(CA, 8'h06);
		rc(SA, 8'h03);
		pulse_rst(1);
		rc(CA, 8'h06);
		rc(IA, 8'h00);
		pulse_rst(2);
		rc(CA, 8'h02);
		r0 = rst_seen;
		repeat (200) wr(CA, 8'h03);
		chk(32'(rst_seen - r0), 32'h0);
		wr(CA, 8'h00);
		r0 = rst_seen;
		repeat (700) @(posedge mclk_in);
		chk(32'(rst_seen - r0), 32'h0);
		rc(CA, 8'h08);
		pulse_rst(0);
		rc(CA, 8'h40);
		end_of_test;
	end
endmodule : wtc_bench

`default_nettype wire
